// ===== rtl/iet_edge_det.sv
`timescale 1ns/1ns
module iet_edge_det (
	input  logic       mclk,
	input  logic       rst,
	input  logic       pin,
	input  logic [1:0] mode,
	output logic       edge_pulse
);
	import iet_pkg::*;

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_reg  <= 1'b0;
			sync2_reg  <= 1'b0;
			prev_reg   <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			sync1_reg  <= pin;
			sync2_reg  <= sync1_reg;
			prev_reg   <= sync2_reg;
			edge_pulse <= (mode[0] & sync2_reg & ~prev_reg) | (mode[1] & ~sync2_reg & prev_reg);
		end
	end

	chk_edge_rise: assert property (@(posedge mclk) disable iff (rst)
		(mode == EDGE_RISE && sync2_reg && !prev_reg) |=> edge_pulse)
		else $error("rising edge not flagged");
	chk_edge_fall_only: assert property (@(posedge mclk) disable iff (rst)
		(mode == EDGE_FALL && sync2_reg && !prev_reg) |=> !edge_pulse)
		else $error("rising edge flagged in falling mode");
endmodule

// ===== rtl/iet_pkg.sv
package iet_pkg;

	localparam int NODES     = 16;
	localparam int CHANS     = 8;
	localparam int FAST      = 4;
	localparam int STK_DEPTH = 16;

	// response figures in cpu clocks (mclk is the cpu clock)
	localparam int RESP_CYC_CACHE   = 7;
	localparam int RESP_CYC_NOCACHE = 11;
	localparam logic [3:0] RESP_LD_CACHE   = 4'(RESP_CYC_CACHE - 1);
	localparam logic [3:0] RESP_LD_NOCACHE = 4'(RESP_CYC_NOCACHE - 1);

	// register map, byte addresses
	localparam logic [11:0] NODE_BASE = 12'h000;
	localparam logic [11:0] NODE_MASK = 12'hFC3;
	localparam logic [11:0] LEVEL_OFF = 12'h040;
	localparam logic [11:0] STAT_OFF  = 12'h044;
	localparam logic [11:0] MASK_OFF  = 12'h048;
	localparam logic [11:0] EDGE_OFF  = 12'h04C;
	localparam logic [11:0] CHAN_BASE = 12'h080;
	localparam logic [11:0] CHAN_MASK = 12'hF83;
	localparam logic [1:0]  CH_SRC    = 2'h0;
	localparam logic [1:0]  CH_DST    = 2'h1;
	localparam logic [1:0]  CH_CNT    = 2'h2;
	localparam logic [1:0]  CH_CTL    = 2'h3;

	// status register layout
	localparam int ST_ZERO_LSB = 0;
	localparam int ST_OVF_BIT  = 8;
	localparam int ST_TRAP_BIT = 9;
	localparam int STAT_W      = 10;

	localparam logic [STAT_W-1:0] STAT_RST = 10'h000;
	localparam logic [STAT_W-1:0] MASK_RST = 10'h000;
	localparam logic [7:0]        EDGE_RST = 8'h00;

	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	localparam logic [15:0] VEC_BASE       = 16'h0000;
	localparam logic [7:0]  NODE_TRAP_BASE = 8'h10;
	localparam logic [15:0] BYTE_STEP      = 16'h0001;
	localparam logic [15:0] WORD_STEP      = 16'h0002;

	typedef struct packed {
		logic [2:0] chan;
		logic       xfer;
		logic [3:0] prio;
		logic       en;
		logic       req;
	} iet_node_s;

	localparam iet_node_s NODE_RST = '0;

	typedef struct packed {
		logic        cont;
		logic        inc_dst;
		logic        inc_src;
		logic        word;
		logic [7:0]  count;
		logic [15:0] dst;
		logic [15:0] src;
	} iet_chan_s;

	localparam iet_chan_s CHAN_RST = '0;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} iet_apb_s;

	typedef struct packed {
		logic [15:0] src;
		logic [15:0] dst;
		logic        word;
	} iet_xfer_s;

	typedef enum logic [1:0] {ST_IDLE, ST_RESP, ST_XFER} iet_state_e;

	function automatic logic [15:0] vec_of(input logic [7:0] num);
		return VEC_BASE + {6'h00, num, 2'h0};
	endfunction

endpackage

// ===== rtl/iet_top.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module iet_top (
	input  logic              mclk,
	input  logic              rst,
	input  iet_pkg::iet_apb_s apb,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  logic [15:0]       periph_req,
	input  logic [3:0]        fast_pin,
	input  logic              jump_cache_en,
	input  logic              cpu_trap,
	input  logic [7:0]        cpu_trap_num,
	input  logic              cpu_return,
	output logic              cpu_branch,
	output logic [15:0]       cpu_vector,
	output logic [3:0]        cpu_level,
	output logic              xfer_req,
	output iet_pkg::iet_xfer_s xfer,
	input  logic              xfer_ack,
	output logic              irq
);
	import iet_pkg::*;

	iet_node_s         node_reg [NODES];
	iet_chan_s         chan_reg [CHANS];
	iet_state_e        state_reg;
	logic [3:0]        cnt_reg;
	logic [3:0]        level_stack [STK_DEPTH];
	logic [4:0]        sp_reg;
	logic              trap_pend_reg;
	logic [7:0]        trap_num_reg;
	logic [2:0]        xch_reg;
	logic [STAT_W-1:0] stat_reg;
	logic [STAT_W-1:0] mask_reg;
	logic [7:0]        edge_reg;
	logic [FAST-1:0]   fast_hit;
	logic [NODES-1:0]  hw_set;
	logic              win_ok;
	logic [3:0]        win_idx;
	logic [3:0]        win_prio;
	logic [2:0]        win_chan;
	logic              to_xfer;
	logic              can_go;
	logic              go_std;
	logic              go_xfer;
	logic              take_trap;
	logic              xfer_done;
	logic              apb_wr;
	logic              apb_sample;
	logic              node_hit;
	logic              chan_hit;
	logic [3:0]        nidx;
	logic [2:0]        cidx;
	logic [1:0]        csub;
	logic [31:0]       rd_data;
	logic              mapped;
	logic [STAT_W-1:0] ev;
	logic [15:0]       step;
	logic [15:0]       src_cur;
	logic [7:0]        cnt_cur;

	genvar f;
	generate
		for (f = 0; f < FAST; f++) begin : g_fast
			iet_edge_det u_edge (
				.mclk       (mclk),
				.rst        (rst),
				.pin        (fast_pin[f]),
				.mode       (edge_reg[2*f+1:2*f]),
				.edge_pulse (fast_hit[f])
			);
		end
	endgenerate

	// fast pins feed the top nodes
	assign hw_set = periph_req | {fast_hit, {(NODES-FAST){1'b0}}};

	// register decode
	assign node_hit   = (apb.paddr & NODE_MASK) == NODE_BASE;
	assign chan_hit   = (apb.paddr & CHAN_MASK) == CHAN_BASE;
	assign nidx       = apb.paddr[5:2];
	assign cidx       = apb.paddr[6:4];
	assign csub       = apb.paddr[3:2];
	assign apb_wr     = apb.psel & apb.penable & apb.pwrite & pready;
	assign apb_sample = apb.psel & apb.penable & ~pready;

	always_comb begin
		rd_data = 32'h0000_0000;
		mapped  = 1'b1;
		if (node_hit) begin
			rd_data = {22'h00_0000, node_reg[nidx]};
		end else if (chan_hit) begin
			unique case (csub)
				CH_SRC: rd_data = {16'h0000, chan_reg[cidx].src};
				CH_DST: rd_data = {16'h0000, chan_reg[cidx].dst};
				CH_CNT: rd_data = {24'h00_0000, chan_reg[cidx].count};
				CH_CTL: rd_data = {28'h000_0000, chan_reg[cidx].cont, chan_reg[cidx].inc_dst,
					chan_reg[cidx].inc_src, chan_reg[cidx].word};
			endcase
		end else begin
			unique case (apb.paddr)
				LEVEL_OFF: rd_data = {28'h000_0000, cpu_level};
				STAT_OFF:  rd_data = {22'h00_0000, stat_reg};
				MASK_OFF:  rd_data = {22'h00_0000, mask_reg};
				EDGE_OFF:  rd_data = {24'h00_0000, edge_reg};
				default:   mapped = 1'b0;
			endcase
		end
	end

	// one wait state: data captured in first access cycle, pready next
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_sample;
			if (apb_sample) begin
				prdata  <= apb.pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= ~mapped;
			end
		end
	end

	// arbitration: strictly above current level, ties to lowest index
	always_comb begin
		win_ok   = 1'b0;
		win_idx  = 4'h0;
		win_prio = 4'h0;
		for (int i = 0; i < NODES; i++) begin
			if (node_reg[i].req && node_reg[i].en && node_reg[i].prio > cpu_level &&
				(!win_ok || node_reg[i].prio > win_prio)) begin
				win_ok   = 1'b1;
				win_idx  = 4'(i);
				win_prio = node_reg[i].prio;
			end
		end
	end

	assign win_chan  = node_reg[win_idx].chan;
	assign to_xfer   = node_reg[win_idx].xfer && (chan_reg[win_chan].cont || chan_reg[win_chan].count != 8'h00);
	assign take_trap = state_reg == ST_IDLE && trap_pend_reg;
	assign can_go    = state_reg == ST_IDLE && !trap_pend_reg && win_ok && !cpu_return;
	assign go_std    = can_go && !to_xfer;
	assign go_xfer   = can_go && to_xfer;
	assign xfer_done = state_reg == ST_XFER && xfer_ack;
	assign step      = chan_reg[xch_reg].word ? WORD_STEP : BYTE_STEP;
	assign src_cur   = chan_reg[xch_reg].src;
	assign cnt_cur   = chan_reg[xch_reg].count;

	// node control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NODES; i++) begin
				node_reg[i] <= NODE_RST;
			end
		end else begin
			for (int i = 0; i < NODES; i++) begin
				if (apb_wr && node_hit && nidx == 4'(i)) begin
					node_reg[i]     <= apb.pwdata[9:0];
					node_reg[i].req <= apb.pwdata[0] | hw_set[i];
				end else if ((go_std || go_xfer) && win_idx == 4'(i)) begin
					node_reg[i].req <= hw_set[i];
				end else if (hw_set[i]) begin
					node_reg[i].req <= 1'b1;
				end
			end
		end
	end

	// software trap request from the cpu
	always_ff @(posedge mclk) begin
		if (rst) begin
			trap_pend_reg <= 1'b0;
			trap_num_reg  <= 8'h00;
		end else if (cpu_trap) begin
			trap_pend_reg <= 1'b1;
			trap_num_reg  <= cpu_trap_num;
		end else if (take_trap) begin
			trap_pend_reg <= 1'b0;
		end
	end

	// service sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg  <= ST_IDLE;
			cnt_reg    <= 4'h0;
			cpu_branch <= 1'b0;
			cpu_vector <= VEC_BASE;
			xfer_req   <= 1'b0;
			xfer       <= '0;
			xch_reg    <= 3'h0;
		end else begin
			cpu_branch <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (take_trap) begin
						state_reg  <= ST_RESP;
						cnt_reg    <= jump_cache_en ? RESP_LD_CACHE : RESP_LD_NOCACHE;
						cpu_vector <= vec_of(trap_num_reg);
					end else if (go_std) begin
						state_reg  <= ST_RESP;
						cnt_reg    <= jump_cache_en ? RESP_LD_CACHE : RESP_LD_NOCACHE;
						cpu_vector <= vec_of(NODE_TRAP_BASE + {4'h0, win_idx});
					end else if (go_xfer) begin
						state_reg <= ST_XFER;
						xfer_req  <= 1'b1;
						xch_reg   <= win_chan;
						xfer.src  <= chan_reg[win_chan].src;
						xfer.dst  <= chan_reg[win_chan].dst;
						xfer.word <= chan_reg[win_chan].word;
					end
				end
				ST_RESP: begin
					if (cnt_reg == 4'h1) begin
						state_reg  <= ST_IDLE;
						cpu_branch <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				ST_XFER: begin
					if (xfer_ack) begin
						state_reg <= ST_IDLE;
						xfer_req  <= 1'b0;
					end
				end
			endcase
		end
	end

	// transfer channels; a software write in the same cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int c = 0; c < CHANS; c++) begin
				chan_reg[c] <= CHAN_RST;
			end
		end else begin
			if (xfer_done) begin
				if (chan_reg[xch_reg].inc_src) begin
					chan_reg[xch_reg].src <= chan_reg[xch_reg].src + step;
				end
				if (chan_reg[xch_reg].inc_dst) begin
					chan_reg[xch_reg].dst <= chan_reg[xch_reg].dst + step;
				end
				if (!chan_reg[xch_reg].cont) begin
					chan_reg[xch_reg].count <= chan_reg[xch_reg].count - 8'h01;
				end
			end
			if (apb_wr && chan_hit) begin
				unique case (csub)
					CH_SRC: chan_reg[cidx].src <= apb.pwdata[15:0];
					CH_DST: chan_reg[cidx].dst <= apb.pwdata[15:0];
					CH_CNT: chan_reg[cidx].count <= apb.pwdata[7:0];
					CH_CTL: {chan_reg[cidx].cont, chan_reg[cidx].inc_dst, chan_reg[cidx].inc_src,
						chan_reg[cidx].word} <= apb.pwdata[3:0];
				endcase
			end
		end
	end

	// priority level and its nesting stack
	always_ff @(posedge mclk) begin
		if (rst) begin
			sp_reg    <= 5'h00;
			cpu_level <= 4'h0;
			for (int s = 0; s < STK_DEPTH; s++) begin
				level_stack[s] <= 4'h0;
			end
		end else if (go_std) begin
			cpu_level <= win_prio;
			if (sp_reg != 5'(STK_DEPTH)) begin
				level_stack[sp_reg[3:0]] <= cpu_level;
				sp_reg                   <= sp_reg + 5'h01;
			end
		end else if (cpu_return && sp_reg != 5'h00) begin
			cpu_level <= level_stack[4'(sp_reg - 5'h01)];
			sp_reg    <= sp_reg - 5'h01;
		end
	end

	// events: counter exhausted, nesting overflow, trap taken
	always_comb begin
		ev = '0;
		if (xfer_done && !chan_reg[xch_reg].cont && chan_reg[xch_reg].count == 8'h01) begin
			ev[ST_ZERO_LSB + 32'(xch_reg)] = 1'b1;
		end
		ev[ST_OVF_BIT]  = go_std && sp_reg == 5'(STK_DEPTH);
		ev[ST_TRAP_BIT] = take_trap;
	end

	// control registers, sticky status cleared by its read
	always_ff @(posedge mclk) begin
		if (rst) begin
			stat_reg <= STAT_RST;
			mask_reg <= MASK_RST;
			edge_reg <= EDGE_RST;
			irq      <= 1'b0;
		end else begin
			if (apb_sample && !apb.pwrite && apb.paddr == STAT_OFF) begin
				stat_reg <= ev;
			end else begin
				stat_reg <= stat_reg | ev;
			end
			if (apb_wr && apb.paddr == MASK_OFF) begin
				mask_reg <= apb.pwdata[STAT_W-1:0];
			end
			if (apb_wr && apb.paddr == EDGE_OFF) begin
				edge_reg <= apb.pwdata[7:0];
			end
			irq <= |(stat_reg & mask_reg);
		end
	end

	sequence s_std_fast;
		go_std && jump_cache_en;
	endsequence
	sequence s_std_slow;
		go_std && !jump_cache_en;
	endsequence

	chk_resp_cache: assert property (@(posedge mclk) disable iff (rst)
		s_std_fast |=> !cpu_branch [*6] ##1 cpu_branch)
		else $error("response with jump cache not 7 clocks");
	chk_resp_nocache: assert property (@(posedge mclk) disable iff (rst)
		s_std_slow |-> ##11 cpu_branch)
		else $error("response without jump cache not 11 clocks");
	chk_xfer_steal: assert property (@(posedge mclk) disable iff (rst)
		xfer_done |=> !xfer_req && !cpu_branch)
		else $error("transfer held cpu beyond ack cycle");
	chk_src_step: assert property (@(posedge mclk) disable iff (rst)
		(xfer_done && chan_reg[xch_reg].inc_src && !apb_wr) |=> src_cur == $past(src_cur) + $past(step))
		else $error("source pointer not advanced");
	chk_count_dec: assert property (@(posedge mclk) disable iff (rst)
		(xfer_done && !chan_reg[xch_reg].cont && !apb_wr) |=> cnt_cur == $past(cnt_cur) - 8'h01)
		else $error("transfer counter not decremented");
	chk_zero_std: assert property (@(posedge mclk) disable iff (rst)
		(can_go && chan_reg[win_chan].count == 8'h00 && !chan_reg[win_chan].cont) |-> go_std)
		else $error("exhausted channel did not give standard interrupt");
	chk_preempt_higher: assert property (@(posedge mclk) disable iff (rst)
		go_std |=> cpu_level > $past(cpu_level))
		else $error("service entered without higher priority");
	chk_vector_node: assert property (@(posedge mclk) disable iff (rst)
		go_std |=> cpu_vector == vec_of(NODE_TRAP_BASE + {4'h0, $past(win_idx)}))
		else $error("wrong node vector");
	chk_req_clear: assert property (@(posedge mclk) disable iff (rst)
		(can_go && !hw_set[win_idx] && !apb_wr) |=> !node_reg[$past(win_idx)].req)
		else $error("request flag not cleared on acceptance");
	chk_sw_request: assert property (@(posedge mclk) disable iff (rst)
		(apb_wr && node_hit && apb.pwdata[0]) |=> node_reg[$past(nidx)].req)
		else $error("software request bit lost");
endmodule

// ===== verification/iet_cpu_model.sv
`timescale 1ns/1ns
module iet_cpu_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       xfer_req,
	input  wire logic [2:0] stall,
	output logic            xfer_ack
);
	logic [2:0] wait_reg;

	// cpu gives up one cycle per request, after a stall of some cycles
	always_ff @(posedge mclk) begin
		if (rst || !xfer_req || xfer_ack) begin
			wait_reg <= 3'h0;
			xfer_ack <= 1'b0;
		end else if (wait_reg == stall) begin
			xfer_ack <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 3'h1;
		end
	end
endmodule

// ===== verification/interrupt_and_event_transfer_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end
module interrupt_and_event_transfer_tb;
	import iet_pkg::*;
	typedef struct {logic [15:0] vec; logic [3:0] lvl; int due;} iet_note_s;
	logic        mclk, rst, jump_cache_en, cpu_trap, cpu_return, xfer_ack, pready, pslverr;
	logic        cpu_branch, xfer_req, irq, err, e;
	logic [15:0] periph_req, cpu_vector;
	logic [3:0]  fast_pin, cpu_level;
	logic [7:0]  cpu_trap_num;
	logic [31:0] prdata, rd;
	logic [2:0]  stall;
	iet_apb_s    apb;
	iet_xfer_s   xfer, ex, xe;
	iet_note_s   nt;
	iet_note_s   bq[$];
	iet_xfer_s   xq[$];
	int          bad_count = 0, samples_checked = 0, cyc = 0, seed, i, c, n, m;

	iet_top dut (.mclk(mclk), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_req(periph_req), .fast_pin(fast_pin), .jump_cache_en(jump_cache_en), .cpu_trap(cpu_trap),
		.cpu_trap_num(cpu_trap_num), .cpu_return(cpu_return), .cpu_branch(cpu_branch),
		.cpu_vector(cpu_vector), .cpu_level(cpu_level), .xfer_req(xfer_req), .xfer(xfer),
		.xfer_ack(xfer_ack), .irq(irq));
	iet_cpu_model cpu (.mclk(mclk), .rst(rst), .xfer_req(xfer_req), .stall(stall), .xfer_ack(xfer_ack));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watcher: each branch or stolen cycle takes the oldest note
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
		if (cpu_branch === 1'b1) begin
			if (bq.size() == 0) `CHK("spurious branch", 1'b0, 1'b1)
			else begin
				nt = bq.pop_front();
				`CHK("vector", nt.vec, cpu_vector)
				`CHK("level", nt.lvl, cpu_level)
				if (nt.due != 0) `CHK("latency", nt.due, cyc)
			end
		end
		if (xfer_req === 1'b1 && xfer_ack === 1'b1) begin
			if (xq.size() == 0) `CHK("spurious transfer", 1'b0, 1'b1)
			else begin
				xe = xq.pop_front();
				`CHK("transfer", xe, xfer)
			end
		end
	end

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge mclk);
		apb.penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		err = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] d);
		bus(1'b0, a, 32'h0000_0000);
		`CHK("read data", d, rd)
		`CHK("slave error", 1'b0, err)
	endtask

	function automatic logic [31:0] nctl(input logic [3:0] p, input logic xf, input logic [2:0] ch, input logic en);
		return {22'h00_0000, ch, xf, p, en, 1'b0};
	endfunction

	function automatic logic [15:0] nv(input int k);
		return VEC_BASE + 16'((int'(NODE_TRAP_BASE) + k) * 4);
	endfunction

	task automatic pulse(input logic [15:0] msk, input int k, input logic [3:0] l);
		@(posedge mclk);
		periph_req <= msk;
		if (k >= 0) bq.push_back('{nv(k), l, cyc + (jump_cache_en ? 9 : 13)});
		@(posedge mclk);
		periph_req <= 16'h0000;
	endtask

	task automatic drain();
		for (int t = 0; t < 300 && (bq.size() + xq.size()) > 0; t++) @(posedge mclk);
		repeat (3) @(posedge mclk);
	endtask

	task automatic ret();
		@(posedge mclk);
		cpu_return <= 1'b1;
		@(posedge mclk);
		cpu_return <= 1'b0;
	endtask

	initial begin
		seed = 58026;
		apb = '0;
		periph_req = 16'h0000;
		fast_pin = 4'h0;
		jump_cache_en = 1'b1;
		cpu_trap = 1'b0;
		cpu_trap_num = 8'h00;
		cpu_return = 1'b0;
		stall = 3'h0;
		rst = 1'b1;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rchk(NODE_BASE + 12'h004, 32'h0000_0000);
		bus(1'b0, 12'hFF0, 32'h0000_0000);
		`CHK("unmapped", 1'b1, err)
		for (n = 0; n < NODES; n++) begin
			m = 1 + $unsigned($random(seed)) % 15;
			bus(1'b1, NODE_BASE + 12'(4 * n), nctl(4'(m), 1'b0, 3'h0, 1'b1));
			jump_cache_en <= n[0];
			pulse(16'h0001 << n, n, 4'(m));
			drain();
			rchk(NODE_BASE + 12'(4 * n), nctl(4'(m), 1'b0, 3'h0, 1'b1));
			rchk(LEVEL_OFF, 32'(m));
			ret();
		end
		// nesting: equal level waits, higher level preempts, disabled stays pending
		bus(1'b1, NODE_BASE + 12'h004, nctl(4'h5, 1'b0, 3'h0, 1'b1));
		bus(1'b1, NODE_BASE + 12'h008, nctl(4'h9, 1'b0, 3'h0, 1'b1));
		bus(1'b1, NODE_BASE + 12'h00C, nctl(4'hC, 1'b0, 3'h0, 1'b1));
		bus(1'b1, NODE_BASE + 12'h010, nctl(4'h9, 1'b0, 3'h0, 1'b1));
		bus(1'b1, NODE_BASE + 12'h014, nctl(4'hF, 1'b0, 3'h0, 1'b0));
		pulse(16'h0026, 2, 4'h9);
		drain();
		pulse(16'h0010, -1, 4'h0);
		repeat (20) @(posedge mclk);
		pulse(16'h0008, 3, 4'hC);
		drain();
		ret();
		repeat (20) @(posedge mclk);
		bq.push_back('{nv(4), 4'h9, 0});
		ret();
		drain();
		bq.push_back('{nv(1), 4'h5, 0});
		ret();
		drain();
		ret();
		rchk(NODE_BASE + 12'h014, nctl(4'hF, 1'b0, 3'h0, 1'b0) | 32'h1);
		bq.push_back('{nv(5), 4'hF, 0});
		bus(1'b1, NODE_BASE + 12'h014, nctl(4'hF, 1'b0, 3'h0, 1'b1) | 32'h1);
		drain();
		ret();
		// traps, with and without the status mask
		for (i = 0; i < 4; i++) begin
			m = $random(seed);
			bus(1'b1, MASK_OFF, i[0] ? 32'h0000_0200 : 32'h0000_0000);
			bq.push_back('{VEC_BASE + 16'(4 * int'(m[7:0])), 4'h0, 0});
			@(posedge mclk);
			cpu_trap <= 1'b1;
			cpu_trap_num <= m[7:0];
			@(posedge mclk);
			cpu_trap <= 1'b0;
			drain();
			`CHK("irq", i[0], irq)
			rchk(STAT_OFF, 32'h0000_0200);
			repeat (2) @(posedge mclk);
			`CHK("irq after read", 1'b0, irq)
		end
		// fast pin 0 on node 12 in every edge mode
		bus(1'b1, NODE_BASE + 12'h030, nctl(4'h3, 1'b0, 3'h0, 1'b1));
		for (m = 0; m < 4; m++) begin
			bus(1'b1, EDGE_OFF, 32'(m));
			for (i = 0; i < 2; i++) begin
				e = (m == EDGE_RISE && i == 0) || (m == EDGE_FALL && i == 1) || m == EDGE_BOTH;
				if (e) bq.push_back('{nv(12), 4'h3, 0});
				@(posedge mclk);
				fast_pin <= {3'($random(seed)), ~fast_pin[0]};
				repeat (20) @(posedge mclk);
				drain();
				if (e) ret();
			end
		end
		// channels 0 to 6: two transfers, then count zero gives a standard service; channel 7 is continuous, three transfers
		for (c = 0; c < CHANS; c++) begin
			m = $random(seed);
			ex.src = 16'($random(seed));
			ex.dst = 16'($random(seed));
			ex.word = m[0];
			bus(1'b1, CHAN_BASE + 12'(16 * c), 32'(ex.src));
			bus(1'b1, CHAN_BASE + 12'(16 * c + 4), 32'(ex.dst));
			bus(1'b1, CHAN_BASE + 12'(16 * c + 8), 32'h0000_0002);
			bus(1'b1, CHAN_BASE + 12'(16 * c + 12), 32'({c == 7, m[2:0]}));
			bus(1'b1, NODE_BASE + 12'(4 * c), nctl(4'h1, 1'b1, 3'(c), 1'b1));
			for (i = 0; i < 3; i++) begin
				stall <= 3'($random(seed));
				if (i < 2 || c == 7) begin
					xq.push_back(ex);
					if (m[1]) ex.src += ex.word ? WORD_STEP : BYTE_STEP;
					if (m[2]) ex.dst += ex.word ? WORD_STEP : BYTE_STEP;
				end else
					bq.push_back('{nv(c), 4'h1, 0});
				pulse(16'h0001 << c, -1, 4'h0);
				drain();
			end
			if (c != 7) ret();
			rchk(CHAN_BASE + 12'(16 * c + 8), c == 7 ? 32'h0000_0002 : 32'h0000_0000);
			rchk(CHAN_BASE + 12'(16 * c), 32'(ex.src));
			rchk(CHAN_BASE + 12'(16 * c + 4), 32'(ex.dst));
			rchk(STAT_OFF, c == 7 ? 32'h0000_0000 : 32'h0000_0001 << c);
		end
		drain();
		close_out();
	end
endmodule
